/* File: src/dpp_pkg.sv */
// Shared constants and types for the dual parallel port controller
package dpp_pkg;
   localparam int DW = 8;
   localparam int NPORT = 2;

   // Port modes, carried in control word bits 7:6
   localparam logic [1:0] MODE_OUT = 2'h0;
   localparam logic [1:0] MODE_IN = 2'h1;
   localparam logic [1:0] MODE_BIDIR = 2'h2;
   localparam logic [1:0] MODE_BIT = 2'h3;

   // Control word keys in the low nibble, and field positions
   localparam logic [3:0] CW_MODE_KEY = 4'hf;
   localparam logic [3:0] CW_INTCTL_KEY = 4'h7;
   localparam logic [3:0] CW_INTEN_KEY = 4'h3;
   localparam int CW_VEC_BIT = 0;
   localparam int CW_MODE_LSB = 6;
   localparam int CW_IE_BIT = 7;
   localparam int CW_LVL_BIT = 5;
   localparam int CW_MASKF_BIT = 4;

   // Return-from-interrupt opcode pair seen on the data bus
   localparam logic [7:0] IRQ_RETURN_OP_OP_PREFIX = 8'hed;
   localparam logic [7:0] IRQ_RETURN_OP_OP_CODE = 8'h4d;

   // Reset values
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] VEC_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // Synchroniser idle value: ce_n,cd,bsel,io_cycle_req_n_n,rd_n,m1_n,port_a_strobe_n_n,port_b_strobe_n_n,iei,d,pa,pb
   localparam int SYNC_W = 33;
   localparam logic [SYNC_W-1:0] SYNC_RST = {9'h13e, 24'h000000};

   // Fetch-strobe reset: low time in system clock periods
   localparam int CLK_PERIOD_NS = 4;
   localparam int FETCH_RST_PERIODS = 2;
   localparam int FETCH_RST_NS = FETCH_RST_PERIODS * CLK_PERIOD_NS;
   localparam int FETCH_RST_CYC = (FETCH_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] FETCH_RST_CNT = 2'(FETCH_RST_CYC);

   // Follow-on word expected after a control word
   typedef enum logic [1:0] {CW_IDLE, CW_DIR, CW_MASK} dpp_cw_st_t;
endpackage : dpp_pkg

/* File: src/dpp_port_ctrl.sv */
// Dual 8-bit parallel port controller: host bus, two ports, interrupt chain
`timescale 1ns/1ps
// Functional notes
// - Control/data select high means control word
// - Port select low is port one
// - Register access only while chip select is low; acknowledge ignores it
// - I/O request qualifies every register access
// - Fetch plus I/O request means acknowledge
// - Data bus floats unless driving read data or an interrupt vector
// - Two 8-bit ports with strobe/ready pairs
// - Four modes; bidirectional on first port only
// - Strobe meaning follows the port mode
// - Ready output meaning follows the port mode
// - Bidirectional first port repurposes second handshake
// - Interrupt request is open drain
// - High chain input permits interrupt requests
// - Chain output feeds next lower device
// - Static state survives a stopped clock
// - Long fetch strobe with read/request high resets
// - Reset: input mode, masked, floating, ready low
// - Low chain input forces output low, no request
// - Watch bus for return opcode, end service
module dpp_port_ctrl
   import dpp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce_n,
   input wire logic i_cd,
   input wire logic i_bsel,
   input wire logic i_io_cycle_req_n,
   input wire logic i_rd_n,
   input wire logic i_fetch_cycle_n,
   input wire logic [DW-1:0] i_host_data_bus,
   output logic [DW-1:0] o_host_data_bus,
   output logic o_host_data_bus_oe,
   input wire logic [DW-1:0] i_port_a_lines,
   output logic [DW-1:0] o_port_a_lines,
   output logic [DW-1:0] o_port_a_lines_oe,
   input wire logic [DW-1:0] i_port_b_lines,
   output logic [DW-1:0] o_port_b_lines,
   output logic [DW-1:0] o_port_b_lines_oe,
   input wire logic i_port_a_strobe_n,
   input wire logic i_port_b_strobe_n,
   output logic o_port_a_ready,
   output logic o_port_b_ready,
   input wire logic i_chain_enable_in,
   output logic o_chain_enable_out,
   output logic o_int_n,
   output logic o_int_n_oe
);
   logic [SYNC_W-1:0] sync1_q, sync2_q;
   logic s_ce_n, s_cd, s_bsel, s_io_cycle_req_n_n, s_rd_n, s_m1_n, s_port_a_strobe_n_n, s_port_b_strobe_n_n, s_iei;
   logic [DW-1:0] s_data, s_pa, s_pb;
   logic port_a_strobe_n_prev_q, port_b_strobe_n_prev_q, m1_prev_q, acc_q, ack_q, fetch_q, irq_return_op_arm_q;
   logic a_rise, b_rise, io_sel, acc_start, wr_pulse, acc_end, ack, ack_start;
   logic fetch, fetch_end, a_bidir, soft_rst, any_svc, any_pend, int_req, vec_drive;
   logic rd_act_q, rd_port_q, rd_cd_q, grant_q;
   logic [1:0] fetch_cnt_q;
   logic [DW-1:0] op_q;
   logic [1:0] mode_q [NPORT];
   dpp_cw_st_t cw_st_q [NPORT];
   logic [DW-1:0] out_q [NPORT], dir_q [NPORT], mask_q [NPORT], vec_q [NPORT];
   logic [NPORT-1:0] cfg_q, ie_q, lvl_q, rdy_out_q, pend_q, svc_q, match_q;
   logic [NPORT-1:0] push, pop, buf_rdy, buf_vld, match, ev;
   logic [DW-1:0] buf_dat [NPORT];
   logic [DW-1:0] rd_val;

   // Every pin passes two flops before any logic reads it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end else begin
         sync1_q <= {i_ce_n, i_cd, i_bsel, i_io_cycle_req_n, i_rd_n, i_fetch_cycle_n,
                     i_port_a_strobe_n, i_port_b_strobe_n, i_chain_enable_in,
                     i_host_data_bus, i_port_a_lines, i_port_b_lines};
         sync2_q <= sync1_q;
      end
   end
   assign {s_ce_n, s_cd, s_bsel, s_io_cycle_req_n_n, s_rd_n, s_m1_n, s_port_a_strobe_n_n, s_port_b_strobe_n_n, s_iei,
           s_data, s_pa, s_pb} = sync2_q;

   // Bus cycle decode
   assign io_sel = !s_ce_n && !s_io_cycle_req_n_n && s_m1_n;
   assign acc_start = io_sel && !acc_q;
   assign acc_end = acc_q && !io_sel;
   assign wr_pulse = acc_start && s_rd_n;
   assign ack = !s_m1_n && !s_io_cycle_req_n_n;
   assign ack_start = ack && !ack_q;
   assign fetch = !s_m1_n && !s_rd_n && s_io_cycle_req_n_n;
   assign fetch_end = fetch_q && !fetch;
   assign a_rise = s_port_a_strobe_n_n && !port_a_strobe_n_prev_q;
   assign b_rise = s_port_b_strobe_n_n && !port_b_strobe_n_prev_q;
   assign a_bidir = cfg_q[0] && (mode_q[0] == MODE_BIDIR);
   // Fetch strobe held low with read and request high, released
   assign soft_rst = s_m1_n && !m1_prev_q && (fetch_cnt_q >= FETCH_RST_CNT);

   // Edge history and fetch-reset timer; all static flops, so a stopped clock keeps state
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         port_a_strobe_n_prev_q <= 1'b1;
         port_b_strobe_n_prev_q <= 1'b1;
         m1_prev_q <= 1'b1;
         acc_q <= 1'b0;
         ack_q <= 1'b0;
         fetch_q <= 1'b0;
         fetch_cnt_q <= 2'h0;
      end else begin
         port_a_strobe_n_prev_q <= s_port_a_strobe_n_n;
         port_b_strobe_n_prev_q <= s_port_b_strobe_n_n;
         m1_prev_q <= s_m1_n;
         acc_q <= io_sel;
         ack_q <= ack;
         fetch_q <= fetch;
         if (!s_m1_n && s_rd_n && s_io_cycle_req_n_n) begin
            if (fetch_cnt_q != 2'h3) begin
               fetch_cnt_q <= fetch_cnt_q + 2'h1;
            end
         end else if (s_m1_n) begin
            fetch_cnt_q <= 2'h0;
         end else begin
            fetch_cnt_q <= 2'h0;
         end
      end
   end

   // Control words and output data per port
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int p = 0; p < NPORT; p++) begin
            mode_q[p] <= MODE_IN;
            cw_st_q[p] <= CW_IDLE;
            out_q[p] <= DATA_RST;
            dir_q[p] <= DIR_RST;
            mask_q[p] <= MASK_RST;
            vec_q[p] <= VEC_RST;
         end
         cfg_q <= '0;
         ie_q <= '0;
         lvl_q <= '0;
      end else if (soft_rst) begin
         for (int p = 0; p < NPORT; p++) begin
            mode_q[p] <= MODE_IN;
            cw_st_q[p] <= CW_IDLE;
            dir_q[p] <= DIR_RST;
            mask_q[p] <= MASK_RST;
         end
         cfg_q <= '0;
         ie_q <= '0;
         lvl_q <= '0;
      end else if (wr_pulse && s_cd) begin
         case (cw_st_q[s_bsel])
            CW_DIR: begin
               dir_q[s_bsel] <= s_data;
               cw_st_q[s_bsel] <= CW_IDLE;
            end
            CW_MASK: begin
               mask_q[s_bsel] <= s_data;
               cw_st_q[s_bsel] <= CW_IDLE;
            end
            default: begin
               if (!s_data[CW_VEC_BIT]) begin
                  vec_q[s_bsel] <= s_data;
               end else if (s_data[3:0] == CW_MODE_KEY) begin
                  // Second port cannot take the bidirectional mode
                  if (!(s_bsel && s_data[7:6] == MODE_BIDIR)) begin
                     mode_q[s_bsel] <= s_data[7:6];
                     cfg_q[s_bsel] <= 1'b1;
                     if (s_data[7:6] == MODE_BIT) begin
                        cw_st_q[s_bsel] <= CW_DIR;
                     end
                  end
               end else if (s_data[3:0] == CW_INTCTL_KEY) begin
                  ie_q[s_bsel] <= s_data[CW_IE_BIT];
                  lvl_q[s_bsel] <= s_data[CW_LVL_BIT];
                  if (s_data[CW_MASKF_BIT]) begin
                     cw_st_q[s_bsel] <= CW_MASK;
                  end
               end else if (s_data[3:0] == CW_INTEN_KEY) begin
                  ie_q[s_bsel] <= s_data[CW_IE_BIT];
               end
            end
         endcase
      end else if (wr_pulse) begin
         out_q[s_bsel] <= s_data;
      end
   end

   // Input capture on the strobe's trailing edge
   always_comb begin
      push[0] = cfg_q[0] && (((mode_q[0] == MODE_IN) && a_rise) || (a_bidir && b_rise));
      push[1] = cfg_q[1] && (mode_q[1] == MODE_IN) && !a_bidir && b_rise;
      pop = '0;
      pop[rd_port_q] = acc_end && rd_act_q && !rd_cd_q;
   end

   dpp_skid_buf u_buf_a (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_clr(soft_rst),
      .i_valid(push[0]),
      .i_data(s_pa),
      .o_ready(buf_rdy[0]),
      .o_valid(buf_vld[0]),
      .o_data(buf_dat[0]),
      .i_ready(pop[0])
   );

   dpp_skid_buf u_buf_b (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_clr(soft_rst),
      .i_valid(push[1]),
      .i_data(s_pb),
      .o_ready(buf_rdy[1]),
      .o_valid(buf_vld[1]),
      .o_data(buf_dat[1]),
      .i_ready(pop[1])
   );

   // Bit-mode match and per-port interrupt events
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         match[p] = cfg_q[p] && (mode_q[p] == MODE_BIT) &&
                    (|(~mask_q[p] & dir_q[p] & ((p == 0 ? s_pa : s_pb) ^~ {DW{lvl_q[p]}})));
      end
      ev[0] = push[0] || (match[0] && !match_q[0]) ||
              (cfg_q[0] && (mode_q[0] == MODE_OUT || a_bidir) && a_rise);
      ev[1] = push[1] || (match[1] && !match_q[1]) ||
              (cfg_q[1] && (mode_q[1] == MODE_OUT) && !a_bidir && b_rise);
   end

   // Output-side ready: set by a data write, dropped when the peripheral takes it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdy_out_q <= '0;
         match_q <= '0;
      end else if (soft_rst) begin
         rdy_out_q <= '0;
         match_q <= '0;
      end else begin
         match_q <= match;
         for (int p = 0; p < NPORT; p++) begin
            // New data wins over a same-cycle strobe
            if (wr_pulse && !s_cd && (s_bsel == 1'(p))) begin
               rdy_out_q[p] <= 1'b1;
            end else if ((p == 0 ? a_rise : (b_rise && !a_bidir))) begin
               rdy_out_q[p] <= 1'b0;
            end
         end
      end
   end

   // Daisy chain request and service
   assign any_svc = |svc_q;
   assign any_pend = |pend_q;
   assign int_req = s_iei && !any_svc && any_pend;
   assign vec_drive = ack_start && int_req;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pend_q <= '0;
         svc_q <= '0;
         grant_q <= 1'b0;
         irq_return_op_arm_q <= 1'b0;
         op_q <= DATA_RST;
      end else if (soft_rst) begin
         pend_q <= '0;
         svc_q <= '0;
         grant_q <= 1'b0;
         irq_return_op_arm_q <= 1'b0;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            // A fresh event wins over the acknowledge clear
            if (ev[p] && ie_q[p]) begin
               pend_q[p] <= 1'b1;
            end else if (vec_drive && (pend_q[0] ? (p == 0) : (p == 1))) begin
               pend_q[p] <= 1'b0;
            end
         end
         if (vec_drive) begin
            svc_q[pend_q[0] ? 0 : 1] <= 1'b1;
            grant_q <= 1'b1;
         end else if (!ack) begin
            grant_q <= 1'b0;
         end
         if (fetch) begin
            op_q <= s_data;
         end
         // Opcode pair decode; only the device with chain input high reacts
         if (fetch_end) begin
            irq_return_op_arm_q <= (op_q == IRQ_RETURN_OP_OP_PREFIX);
            if (irq_return_op_arm_q && (op_q == IRQ_RETURN_OP_OP_CODE) && s_iei) begin
               if (svc_q[0]) begin
                  svc_q[0] <= 1'b0;
               end else begin
                  svc_q[1] <= 1'b0;
               end
            end
         end
      end
   end

   // Read data selection
   always_comb begin
      if (s_cd) begin
         rd_val = {2'h0, svc_q[s_bsel], pend_q[s_bsel], rdy_out_q[s_bsel],
                   ie_q[s_bsel], mode_q[s_bsel]};
      end else begin
         case (mode_q[s_bsel])
            MODE_OUT: rd_val = out_q[s_bsel];
            MODE_BIT: rd_val = ((s_bsel ? s_pb : s_pa) & dir_q[s_bsel]) |
                               (out_q[s_bsel] & ~dir_q[s_bsel]);
            default: rd_val = buf_dat[s_bsel];
         endcase
      end
   end

   // Host data bus: drive only for a selected read or a vector
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_host_data_bus <= DATA_RST;
         o_host_data_bus_oe <= 1'b0;
         rd_act_q <= 1'b0;
         rd_port_q <= 1'b0;
         rd_cd_q <= 1'b0;
      end else begin
         if (vec_drive) begin
            o_host_data_bus <= vec_q[pend_q[0] ? 0 : 1];
         end else if (io_sel && !s_rd_n) begin
            o_host_data_bus <= rd_val;
         end
         o_host_data_bus_oe <= (io_sel && !s_rd_n) || vec_drive || (grant_q && ack);
         if (acc_start) begin
            rd_act_q <= !s_rd_n;
            rd_port_q <= s_bsel;
            rd_cd_q <= s_cd;
         end
      end
   end

   // Port pins, ready lines and chain outputs, all registered
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_port_a_lines <= DATA_RST;
         o_port_b_lines <= DATA_RST;
         o_port_a_lines_oe <= '0;
         o_port_b_lines_oe <= '0;
         o_port_a_ready <= 1'b0;
         o_port_b_ready <= 1'b0;
         o_chain_enable_out <= 1'b0;
         o_int_n <= 1'b1;
         o_int_n_oe <= 1'b0;
      end else begin
         o_port_a_lines <= out_q[0];
         o_port_b_lines <= out_q[1];
         if (!cfg_q[0] || soft_rst) begin
            o_port_a_lines_oe <= '0;
            o_port_a_ready <= 1'b0;
         end else begin
            case (mode_q[0])
               MODE_OUT: o_port_a_lines_oe <= '1;
               MODE_BIDIR: o_port_a_lines_oe <= {DW{!s_port_a_strobe_n_n}};
               MODE_BIT: o_port_a_lines_oe <= ~dir_q[0];
               default: o_port_a_lines_oe <= '0;
            endcase
            o_port_a_ready <= (mode_q[0] == MODE_IN) ? buf_rdy[0] :
                              (mode_q[0] != MODE_BIT) && rdy_out_q[0];
         end
         if (a_bidir && !soft_rst) begin
            o_port_b_ready <= buf_rdy[0];
         end else if (!cfg_q[1] || soft_rst) begin
            o_port_b_ready <= 1'b0;
         end else begin
            o_port_b_ready <= (mode_q[1] == MODE_IN) ? buf_rdy[1] :
                              (mode_q[1] == MODE_OUT) && rdy_out_q[1];
         end
         if (!cfg_q[1] || soft_rst) begin
            o_port_b_lines_oe <= '0;
         end else begin
            case (mode_q[1])
               MODE_OUT: o_port_b_lines_oe <= '1;
               MODE_BIT: o_port_b_lines_oe <= ~dir_q[1];
               default: o_port_b_lines_oe <= '0;
            endcase
         end
         o_chain_enable_out <= s_iei && !any_svc && !any_pend;
         // Open drain: pull low or release, never drive high
         o_int_n <= 1'b0;
         o_int_n_oe <= int_req;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_chip_sel;
      (s_ce_n && s_m1_n) |=> !o_host_data_bus_oe;
   endproperty
   a_chip_sel: assert property (p_chip_sel) else $error("bus driven while deselected");

   property p_write_float;
      (wr_pulse && !ack) |=> !o_host_data_bus_oe;
   endproperty
   a_write_float: assert property (p_write_float) else $error("bus driven on write");

   property p_chain_low;
      !s_iei |=> (!o_chain_enable_out && !o_int_n_oe);
   endproperty
   a_chain_low: assert property (p_chain_low) else $error("chain low not obeyed");

   property p_soft_reset;
      soft_rst |=> (o_port_a_lines_oe == '0 && o_port_b_lines_oe == '0 &&
                    !o_port_a_ready && !o_port_b_ready);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("reset state wrong");

   property p_port_b_write;
      (wr_pulse && !s_cd && s_bsel) |=> (out_q[1] == $past(s_data));
   endproperty
   a_port_b_write: assert property (p_port_b_write) else $error("port b data lost");

   property p_ready_on_write;
      (wr_pulse && !s_cd && !s_bsel && cfg_q[0] && mode_q[0] == MODE_OUT && !soft_rst)
         |=> ##1 o_port_a_ready;
   endproperty
   a_ready_on_write: assert property (p_ready_on_write) else $error("ready not raised");

   property p_bidir_b_ready;
      (a_bidir && !buf_rdy[0]) |=> !o_port_b_ready;
   endproperty
   a_bidir_b_ready: assert property (p_bidir_b_ready) else $error("b ready ignores a fill");

   property p_open_drain;
      o_int_n_oe |-> !o_int_n;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("request driven high");

   property p_vector;
      vec_drive |=> (o_host_data_bus_oe &&
                     o_host_data_bus == ($past(pend_q[0]) ? $past(vec_q[0]) : $past(vec_q[1])));
   endproperty
   a_vector: assert property (p_vector) else $error("vector not driven");

   property p_no_b_bidir;
      mode_q[1] != MODE_BIDIR;
   endproperty
   a_no_b_bidir: assert property (p_no_b_bidir) else $error("second port bidirectional");
endmodule : dpp_port_ctrl

/* File: src/dpp_skid_buf.sv */
// Two-entry input buffer with valid/ready on both sides
`timescale 1ns/1ps
module dpp_skid_buf
   import dpp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_clr,
   input wire logic i_valid,
   input wire logic [DW-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [DW-1:0] o_data,
   input wire logic i_ready
);
   logic [DW-1:0] mem_q [2];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   // Full and empty straight from the occupancy count
   assign o_ready = (cnt_q != 2'h2);
   assign o_valid = (cnt_q != 2'h0);
   assign o_data = mem_q[rd_ptr_q];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   // Storage needs no reset; count and pointers do
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_data;
      end
   end

   // Pointer and count update
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else if (i_clr) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         case ({push, pop})
            2'b10: cnt_q <= cnt_q + 2'h1;
            2'b01: cnt_q <= cnt_q - 2'h1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

   property p_buf_bound;
      @(posedge i_clk) disable iff (i_rst) (cnt_q == 2'h2) |=> (cnt_q != 2'h3);
   endproperty
   a_buf_bound: assert property (p_buf_bound) else $error("buffer count overran");
endmodule : dpp_skid_buf

/* File: tb/dpp_periph_model.sv */
// Peripheral model: strobes bytes into one port and resolves its pins
`timescale 1ns/1ps
module dpp_periph_model
   import dpp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_send,
   input wire logic [DW-1:0] i_word,
   input wire logic [DW-1:0] i_dev_lines,
   input wire logic [DW-1:0] i_dev_oe,
   output logic [DW-1:0] o_lines,
   output logic o_strobe_n,
   output logic o_busy
);
   logic [3:0] step_q = 4'h0;
   logic [DW-1:0] own_q = 8'h00;
   // Word held well past the strobe rise, since capture lags by the synchroniser
   always_ff @(posedge i_clk) begin
      if (step_q == 4'h0) begin
         if (i_send) begin
            own_q <= i_word;
            step_q <= 4'h1;
         end else begin
            own_q <= ~own_q; // Released lines toggle so stale data never matches
         end
      end else begin
         step_q <= (step_q == 4'h8) ? 4'h0 : step_q + 4'h1;
      end
   end
   assign o_strobe_n = !(step_q == 4'h2 || step_q == 4'h3);
   assign o_busy = (step_q != 4'h0) || i_send;
   // Each pin shows the device value wherever the device drives it
   assign o_lines = (i_dev_oe & i_dev_lines) | (~i_dev_oe & own_q);
endmodule : dpp_periph_model

/* File: tb/tb_dpp_port_ctrl.sv */
// Self-checking bench for the dual parallel port controller
`timescale 1ns/1ps
module tb_dpp_port_ctrl
   import dpp_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce_n = 1'b1, cd = 1'b0, bsel = 1'b0, io_cycle_req_n_n = 1'b1, rd_n = 1'b1, m1_n = 1'b1;
   logic chain_in = 1'b1;
   logic [DW-1:0] hdrv = 8'h00, hbus, hout, r, pa_o, pa_oe, pb_o, pb_oe, pa_in, pb_in;
   logic [DW-1:0] wa = 8'h00, wb = 8'h00;
   logic host_oe, a_stb, b_stb, a_rdy, b_rdy, chain_out, int_n, int_oe;
   logic sa = 1'b0, sb = 1'b0, busy_a, busy_b;
   int fails = 0, n_tests = 0, cyc = 0;
   // Host sees its own drive only where the device has let go of the bus
   assign hbus = host_oe ? hout : hdrv;
   always #2 clk = ~clk;
   dpp_port_ctrl i_dut (.i_clk(clk), .i_rst(rst), .i_ce_n(ce_n), .i_cd(cd), .i_bsel(bsel),
      .i_io_cycle_req_n(io_cycle_req_n_n), .i_rd_n(rd_n), .i_fetch_cycle_n(m1_n), .i_host_data_bus(hbus),
      .o_host_data_bus(hout), .o_host_data_bus_oe(host_oe), .i_port_a_lines(pa_in),
      .o_port_a_lines(pa_o), .o_port_a_lines_oe(pa_oe), .i_port_b_lines(pb_in),
      .o_port_b_lines(pb_o), .o_port_b_lines_oe(pb_oe), .i_port_a_strobe_n(a_stb),
      .i_port_b_strobe_n(b_stb), .o_port_a_ready(a_rdy), .o_port_b_ready(b_rdy),
      .i_chain_enable_in(chain_in), .o_chain_enable_out(chain_out), .o_int_n(int_n),
      .o_int_n_oe(int_oe));
   dpp_periph_model i_per_a (.i_clk(clk), .i_send(sa), .i_word(wa), .i_dev_lines(pa_o),
      .i_dev_oe(pa_oe), .o_lines(pa_in), .o_strobe_n(a_stb), .o_busy(busy_a));
   dpp_periph_model i_per_b (.i_clk(clk), .i_send(sb), .i_word(wb), .i_dev_lines(pb_o),
      .i_dev_oe(pb_oe), .o_lines(pb_in), .o_strobe_n(b_stb), .o_busy(busy_b));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // One host cycle, held until read data has passed the synchroniser
   task automatic access(input logic c, b, rn, sn, qn, input logic [7:0] w);
      @(posedge clk);
      ce_n <= sn;
      cd <= c;
      bsel <= b;
      rd_n <= rn;
      io_cycle_req_n_n <= qn;
      hdrv <= w;
      repeat (4) @(posedge clk);
      #1 r = hbus;
      @(posedge clk);
      ce_n <= 1'b1;
      io_cycle_req_n_n <= 1'b1;
      rd_n <= 1'b1;
      m1_n <= 1'b1;
      hdrv <= ~w;
      repeat (4) @(posedge clk);
   endtask : access
   // Peripheral strobes one byte in; bench waits for the model to finish
   task automatic send(input logic b, input logic [7:0] w);
      @(posedge clk);
      if (b) begin
         wb <= w;
         sb <= 1'b1;
      end else begin
         wa <= w;
         sa <= 1'b1;
      end
      @(posedge clk);
      sa <= 1'b0;
      sb <= 1'b0;
      for (int i = 0; i < 20 && (busy_a || busy_b); i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : send
   task automatic t_reset();
      check(pa_oe | pb_oe, 8'h00);
      check({6'h00, a_rdy, b_rdy}, 8'h00);
      check({7'h00, host_oe}, 8'h00);
      check(pa_o | pb_o, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_out();
      access(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, {MODE_OUT, 2'h0, CW_MODE_KEY});
      access(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h5a);
      check(pa_o, 8'h5a);
      check(pa_oe, 8'hff);
      check(pb_oe, 8'h00);
      check({7'h00, a_rdy}, 8'h01);
      access(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'ha5);
      check(pa_o, 8'h5a);
      access(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'ha5);
      check(pa_o, 8'h5a);
      send(1'b0, 8'h00);
      check({7'h00, a_rdy}, 8'h00);
      $display("test output mode done");
   endtask : t_out
   task automatic t_in();
      access(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, {MODE_IN, 2'h0, CW_MODE_KEY});
      check({7'h00, b_rdy}, 8'h01);
      send(1'b1, 8'h11);
      send(1'b1, 8'h22);
      check({7'h00, b_rdy}, 8'h00);
      send(1'b1, 8'h33);
      access(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check(r, 8'h11);
      check({7'h00, host_oe}, 8'h00);
      access(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check(r, 8'h22);
      check({7'h00, b_rdy}, 8'h01);
      $display("test input buffer done");
   endtask : t_in
   task automatic t_refuse();
      access(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, {MODE_BIDIR, 2'h0, CW_MODE_KEY});
      access(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check({6'h00, r[1:0]}, {6'h00, MODE_IN});
      $display("test refused mode done");
   endtask : t_refuse
   task automatic t_chain();
      chain_in <= 1'b0;
      repeat (6) @(posedge clk);
      check({7'h00, chain_out}, 8'h00);
      chain_in <= 1'b1;
      repeat (6) @(posedge clk);
      check({6'h00, chain_out, int_oe}, 8'h02);
      $display("test chain done");
   endtask : t_chain
   // Vector, enable, one input event, acknowledge, then the return opcode pair
   task automatic t_irq();
      access(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h40);
      access(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, {1'b1, 3'h0, CW_INTEN_KEY});
      send(1'b1, 8'h44);
      check({5'h00, chain_out, int_oe, int_n}, 8'h02);
      m1_n <= 1'b0;
      access(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
      check(r, 8'h40);
      check({6'h00, chain_out, int_oe}, 8'h00);
      m1_n <= 1'b0;
      access(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, IRQ_RETURN_OP_OP_PREFIX);
      m1_n <= 1'b0;
      access(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, IRQ_RETURN_OP_OP_CODE);
      repeat (2) @(posedge clk);
      check({7'h00, chain_out}, 8'h01);
      $display("test interrupt done");
   endtask : t_irq
   // Port A both ways: second strobe fills A, second ready shows room in A
   task automatic t_bidir();
      access(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, {MODE_BIDIR, 2'h0, CW_MODE_KEY});
      check({6'h00, a_rdy, b_rdy}, 8'h01);
      check(pa_oe, 8'h00);
      send(1'b1, 8'h66);
      send(1'b1, 8'h67);
      access(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h3c);
      check({6'h00, a_rdy, b_rdy}, 8'h02);
      $display("test bidirectional done");
   endtask : t_bidir
   task automatic t_soft();
      m1_n <= 1'b0;
      repeat (4) @(posedge clk);
      m1_n <= 1'b1;
      repeat (6) @(posedge clk);
      check(pa_oe, 8'h00);
      check({6'h00, a_rdy, b_rdy}, 8'h00);
      $display("test fetch reset done");
   endtask : t_soft
   // Hang guard sized well above the whole sequence
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_out();
      t_in();
      t_refuse();
      t_chain();
      t_irq();
      t_bidir();
      t_soft();
      final_report();
   end
endmodule : tb_dpp_port_ctrl
